// *** hw/cc_capture.sv ***
// one capture channel: pin synchroniser, edge select and latched count
`default_nettype none

module cc_capture (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_raw,
    input wire logic enable,
    input wire logic rising,
    input wire logic [15:0] count,
    output logic [15:0] value,
    output logic hit
);
    import cc_pkg::*;

    cap_state_s s_reg;
    cap_state_s s_next;

    // edge seen on the second stage only; first stage feeds nothing else
    always_comb begin
        s_next = s_reg;
        s_next.sync1 = pin_raw;
        s_next.sync2 = s_reg.sync1;
        s_next.prev = s_reg.sync2;
        s_next.hit = 1'b0;
        if (enable && (s_reg.sync2 != s_reg.prev) && (s_reg.sync2 == rising)) begin
            s_next.value = count;
            s_next.hit = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign value = s_reg.value;
    assign hit = s_reg.hit;

    AST_CAP_EDGE: assert property (@(posedge clk) disable iff (rst)
        s_reg.hit |-> $past(enable) && ($past(s_reg.sync2) != $past(s_reg.prev))
            && ($past(s_reg.sync2) == $past(rising)))
        else $error("capture fired without the selected edge");

    AST_CAP_LOAD: assert property (@(posedge clk) disable iff (rst)
        s_reg.hit |-> s_reg.value == $past(count))
        else $error("capture value is not the timer count at the edge");

    AST_CAP_HOLD: assert property (@(posedge clk) disable iff (rst)
        !s_reg.hit |-> $stable(s_reg.value))
        else $error("capture value changed without a capture");

endmodule : cc_capture

`default_nettype wire

// *** hw/cc_tick_gen.sv ***
// tick divider for the free-running timer, full or half microsecond
`default_nettype none
`include "cc_params.svh"

module cc_tick_gen #(
    parameter int FULL_CYC = `CC_TICK_FULL_CYC,
    parameter int HALF_CYC = `CC_TICK_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic half_rate,
    output logic tick
);
    import cc_pkg::*;

    tick_state_s s_reg;
    tick_state_s s_next;
    logic [`CC_DIV_W-1:0] limit;

    // a rate change takes effect at once; the running period ends at the new limit
    always_comb begin
        s_next = s_reg;
        limit = half_rate ? `CC_DIV_W'(HALF_CYC - 1) : `CC_DIV_W'(FULL_CYC - 1);
        s_next.tick = 1'b0;
        if (s_reg.cnt >= limit) begin
            s_next.cnt = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + `CC_DIV_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

    // helper for the period check: cycles since last tick, rate change seen
    logic [`CC_DIV_W-1:0] gap;
    logic gap_ok;
    logic half_seen;
    always_ff @(posedge clk) begin
        if (rst) begin
            gap <= '0;
            gap_ok <= 1'b0;
        end else if (s_reg.tick) begin
            gap <= '0;
            gap_ok <= 1'b1;
        end else begin
            gap <= gap + `CC_DIV_W'(1);
            // a rate change alters the running period, so that one is not judged
            if (half_rate != half_seen) begin
                gap_ok <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        half_seen <= half_rate;
    end

    AST_TICK_RATE: assert property (@(posedge clk) disable iff (rst)
        s_reg.tick && gap_ok && $stable(half_seen) && (half_seen == half_rate)
        |-> gap == (half_rate ? `CC_DIV_W'(HALF_CYC - 1) : `CC_DIV_W'(FULL_CYC - 1)))
        else $error("tick period does not match the selected resolution");

endmodule : cc_tick_gen

`default_nettype wire

// *** hw/cc_unit.sv ***
// capture/compare unit: timer, snapshot, two captures, two compares
// Operation
// - One 16-bit free-running timer is the common time base of all channels.
// - A control bit selects a tick of one or of half a microsecond per count.
// - The snapshot pair holds its value between requests and does not follow the timer.
// - Writing 1 to the snapshot request bit copies the timer into the snapshot pair.
// - Two capture channels; setting a capture activate bit hands its pin to capture at once.
// - A per-channel edge select bit picks rising or falling pin edges for capture.
// - Each capture channel owns a 16-bit register that holds the latched count.
// - On the selected edge the count is latched and a capture interrupt is raised.
// - Two compare channels, each enabled on its pin by its compare activate bit.
// - A per-channel match level bit picks the level the pin takes on a match.
// - Each compare channel owns a 16-bit register holding the target count.
// - Every match drives the pin to its level and raises that channel's interrupt.
// - After reset every shared pin is a general-purpose input.
// - Pin priority is two-wire bus first, capture or compare second, general I/O last.
//
// The address-and-strobe port and the register addresses were decided locally.
`default_nettype none
`include "cc_params.svh"

module cc_unit (
    input wire logic CLK,
    input wire logic RST,
    input wire cc_pkg::bus_req_s BUS,
    input wire logic [1:0] CAPTURE_PIN_IN,
    input wire logic [3:0] GPIO_OUT,
    input wire logic [3:0] GPIO_OE_N,
    input wire logic TWI_SEL,
    input wire logic [1:0] TWI_OUT,
    input wire logic [1:0] TWI_OE_N,
    output logic [7:0] RDATA,
    output logic [3:0] PIN_OUT,
    output logic [3:0] PIN_OE_N,
    output logic [1:0] IRQ_CAPTURE,
    output logic [1:0] IRQ_COMPARE
);
    import cc_pkg::*;

    cc_state_s r;
    cc_state_s n;
    logic tick;
    logic [15:0] count_inc;
    logic [1:0] cap_en;
    logic [1:0] cap_hit;
    logic [1:0][15:0] cap_val;
    ctrl_s wr_ctrl;

    // timer tick at the selected resolution
    cc_tick_gen u_cc_tick_gen (
        .clk(CLK),
        .rst(RST),
        .half_rate(r.ctrl.tick_resolution_select),
        .tick(tick)
    );

    // capture pin 0 shares its pin with the two-wire data line
    assign cap_en[0] = r.sel.capture_activate_bit[0] & ~TWI_SEL;
    assign cap_en[1] = r.sel.capture_activate_bit[1];
    assign count_inc = r.count + `CC_TIMER_STEP;
    assign wr_ctrl = ctrl_s'(BUS.wdata);

    // one capture block per channel
    for (genvar i = 0; i < 2; i++) begin : g_cap
        cc_capture u_cc_capture (
            .clk(CLK),
            .rst(RST),
            .pin_raw(CAPTURE_PIN_IN[i]),
            .enable(cap_en[i]),
            .rising(r.ctrl.capture_edge_select[i]),
            .count(r.count),
            .value(cap_val[i]),
            .hit(cap_hit[i])
        );
    end

    // next state of timer, compares, registers and pins
    always_comb begin
        n = r;
        n.irq_cmp = 2'b00;
        n.irq_cap = cap_hit;
        n.rdata = `CC_BYTE_RESET;
        if (tick) begin
            n.count = count_inc;
        end
        // match is taken as the timer steps onto the target, once per value
        for (int i = 0; i < 2; i++) begin
            if (tick && r.sel.compare_activate_bit[i] && count_inc == r.cmp[i]) begin
                n.cmp_lvl[i] = r.ctrl.compare_match_level[i];
                n.irq_cmp[i] = 1'b1;
            end
        end
        if (BUS.wr) begin
            case (BUS.addr)
                `CC_REG_CTRL: begin
                    n.ctrl = wr_ctrl;
                    n.ctrl.spare = 2'b00;
                    n.ctrl.snapshot_request_bit = 1'b0;
                    if (wr_ctrl.snapshot_request_bit) begin
                        n.snap = r.count;
                    end
                end
                `CC_REG_SEL: begin
                    n.sel = sel_s'(BUS.wdata);
                    n.sel.spare = 4'h0;
                end
                // the high byte waits in a holding byte until the low byte
                `CC_REG_CMP0_HI: n.cmp_hi[0] = BUS.wdata;
                `CC_REG_CMP0_LO: n.cmp[0] = {r.cmp_hi[0], BUS.wdata};
                `CC_REG_CMP1_HI: n.cmp_hi[1] = BUS.wdata;
                `CC_REG_CMP1_LO: n.cmp[1] = {r.cmp_hi[1], BUS.wdata};
                default: n.rdata = `CC_BYTE_RESET;
            endcase
        end
        if (BUS.rd) begin
            case (BUS.addr)
                `CC_REG_CTRL: n.rdata = r.ctrl;
                `CC_REG_SEL: n.rdata = r.sel;
                `CC_REG_SNAP_HI: n.rdata = r.snap[15:8];
                `CC_REG_SNAP_LO: n.rdata = r.snap[7:0];
                `CC_REG_CAP0_HI: n.rdata = cap_val[0][15:8];
                `CC_REG_CAP0_LO: n.rdata = cap_val[0][7:0];
                `CC_REG_CAP1_HI: n.rdata = cap_val[1][15:8];
                `CC_REG_CAP1_LO: n.rdata = cap_val[1][7:0];
                `CC_REG_CMP0_HI: n.rdata = r.cmp[0][15:8];
                `CC_REG_CMP0_LO: n.rdata = r.cmp[0][7:0];
                `CC_REG_CMP1_HI: n.rdata = r.cmp[1][15:8];
                `CC_REG_CMP1_LO: n.rdata = r.cmp[1][7:0];
                default: n.rdata = `CC_BYTE_RESET;
            endcase
        end
        // pin owners in priority order; low enable means we drive
        n.pin_out = GPIO_OUT;
        n.pin_oe_n = GPIO_OE_N;
        if (r.sel.capture_activate_bit[1]) begin
            n.pin_oe_n[1] = 1'b1;
        end
        if (r.sel.compare_activate_bit[1]) begin
            n.pin_out[3] = r.cmp_lvl[1];
            n.pin_oe_n[3] = 1'b0;
        end
        if (TWI_SEL) begin
            n.pin_out[0] = TWI_OUT[0];
            n.pin_oe_n[0] = TWI_OE_N[0];
            n.pin_out[2] = TWI_OUT[1];
            n.pin_oe_n[2] = TWI_OE_N[1];
        end else begin
            if (r.sel.capture_activate_bit[0]) begin
                n.pin_oe_n[0] = 1'b1;
            end
            if (r.sel.compare_activate_bit[0]) begin
                n.pin_out[2] = r.cmp_lvl[0];
                n.pin_oe_n[2] = 1'b0;
            end
        end
    end

    // reset leaves every pin released, so each reads as a plain input
    always_ff @(posedge CLK) begin
        if (RST) begin
            r <= '0;
            r.count <= `CC_TIMER_RESET;
            r.pin_out <= `CC_PINS_LOW;
            r.pin_oe_n <= `CC_PINS_RELEASED;
        end else begin
            r <= n;
        end
    end

    assign RDATA = r.rdata;
    assign PIN_OUT = r.pin_out;
    assign PIN_OE_N = r.pin_oe_n;
    assign IRQ_CAPTURE = r.irq_cap;
    assign IRQ_COMPARE = r.irq_cmp;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    logic snap_wr;
    assign snap_wr = BUS.wr && BUS.addr == `CC_REG_CTRL && wr_ctrl.snapshot_request_bit;

    AST_TIMER_STEP: assert property (tick |=> r.count == 16'($past(r.count) + 16'h0001))
        else $error("timer did not step by one on a tick");

    AST_TIMER_STILL: assert property (!tick |=> $stable(r.count))
        else $error("timer moved without a tick");

    AST_TIMER_WRAP: assert property (tick && r.count == `CC_TIMER_MAX
        |=> r.count == `CC_TIMER_RESET)
        else $error("timer did not wrap to zero");

    AST_SNAP_LOAD: assert property (snap_wr |=> r.snap == $past(r.count))
        else $error("snapshot does not hold the count of the request");

    AST_SNAP_HOLD: assert property (!snap_wr |=> $stable(r.snap))
        else $error("snapshot changed without a request");

    AST_CMP_HIGH_WAITS: assert property (BUS.wr && BUS.addr == `CC_REG_CMP0_HI
        |=> $stable(r.cmp[0]))
        else $error("compare changed on a high byte write");

    AST_CMP_LOAD: assert property (BUS.wr && BUS.addr == `CC_REG_CMP1_LO
        |=> r.cmp[1] == {$past(r.cmp_hi[1]), $past(BUS.wdata)})
        else $error("compare value not assembled from both bytes");

    for (genvar i = 0; i < 2; i++) begin : g_chk
        AST_CMP_MATCH: assert property (
            tick && r.sel.compare_activate_bit[i] && count_inc == r.cmp[i]
            |=> IRQ_COMPARE[i] && r.cmp_lvl[i] == $past(r.ctrl.compare_match_level[i]))
            else $error("compare match missed its interrupt or level");

        AST_CAP_IRQ: assert property (cap_hit[i] |=> IRQ_CAPTURE[i])
            else $error("capture without its interrupt");

        AST_CAP_IRQ_ONLY: assert property (!cap_hit[i] |=> !IRQ_CAPTURE[i])
            else $error("capture interrupt without a capture");

        AST_CMP_GATED: assert property (
            !r.sel.compare_activate_bit[i] |=> !IRQ_COMPARE[i])
            else $error("compare interrupt from an inactive channel");

        AST_CMP_LVL_HOLD: assert property (
            !(tick && r.sel.compare_activate_bit[i] && count_inc == r.cmp[i])
            |=> $stable(r.cmp_lvl[i]))
            else $error("compare level moved without a match");
    end

    AST_CMP_PIN: assert property (!TWI_SEL && r.sel.compare_activate_bit[1]
        |=> !PIN_OE_N[3] && PIN_OUT[3] == $past(r.cmp_lvl[1]))
        else $error("compare pin not driven at its level");

    AST_PIN_PRIORITY: assert property (TWI_SEL
        |=> PIN_OE_N[0] == $past(TWI_OE_N[0]) && PIN_OE_N[2] == $past(TWI_OE_N[1]))
        else $error("two-wire function lost its pins");

    AST_RESET_PINS: assert property (@(posedge CLK) disable iff (1'b0)
        RST |=> PIN_OE_N == `CC_PINS_RELEASED)
        else $error("pins not released after reset");

    // reads answer in the next cycle only; otherwise the read port shows zero
    AST_RDATA_IDLE: assert property (!BUS.rd |=> RDATA == `CC_BYTE_RESET)
        else $error("read data without a read");

    AST_CTRL_READ: assert property (BUS.rd && BUS.addr == `CC_REG_CTRL
        |=> RDATA == $past(r.ctrl))
        else $error("control read back wrong");

    AST_SNAP_READ: assert property (BUS.rd && BUS.addr == `CC_REG_SNAP_LO
        |=> RDATA == $past(r.snap[7:0]))
        else $error("snapshot low byte read back wrong");

    AST_CAP_READ: assert property (BUS.rd && BUS.addr == `CC_REG_CAP1_HI
        |=> RDATA == $past(cap_val[1][15:8]))
        else $error("capture high byte read back wrong");

    AST_CMP_READ: assert property (BUS.rd && BUS.addr == `CC_REG_CMP0_LO
        |=> RDATA == $past(r.cmp[0][7:0]))
        else $error("compare low byte read back wrong");

    // select and compare registers move only on their own writes
    AST_SEL_KEEP: assert property (!(BUS.wr && BUS.addr == `CC_REG_SEL)
        |=> $stable(r.sel))
        else $error("pin select changed without a write");

    AST_CMP1_HIGH_WAITS: assert property (BUS.wr && BUS.addr == `CC_REG_CMP1_HI
        |=> $stable(r.cmp[1]))
        else $error("compare changed on a high byte write");

    AST_CMP_HIGH_KEPT: assert property (BUS.wr && BUS.addr == `CC_REG_CMP0_LO
        |=> r.cmp[0][15:8] == $past(r.cmp_hi[0]))
        else $error("compare high byte not taken from the held byte");

    // a capturing pin is released; the two-wire bus outranks capture
    AST_CAP_PIN_FREE: assert property (r.sel.capture_activate_bit[1] |=> PIN_OE_N[1])
        else $error("capture pin driven while capturing");

    AST_CAP_OFF: assert property (!r.sel.capture_activate_bit[0]
        |-> ##2 !IRQ_CAPTURE[0])
        else $error("capture interrupt from an inactive channel");

    AST_CAP_BLOCKED: assert property (TWI_SEL |-> ##2 !IRQ_CAPTURE[0])
        else $error("capture ran on a two-wire pin");

    AST_TWI_DATA: assert property (TWI_SEL
        |=> PIN_OUT[0] == $past(TWI_OUT[0]) && PIN_OUT[2] == $past(TWI_OUT[1]))
        else $error("two-wire drive lost its pins");

    // with nothing selected the core port owns every pin
    AST_GPIO_DEFAULT: assert property (!TWI_SEL && r.sel == '0
        |=> PIN_OE_N == $past(GPIO_OE_N) && PIN_OUT == $past(GPIO_OUT))
        else $error("port drive not passed through to the pins");

    COV_SNAPSHOT: cover property (snap_wr ##2 BUS.rd && BUS.addr == `CC_REG_SNAP_HI);
    COV_CAPTURE: cover property (cap_hit[0] ##1 IRQ_CAPTURE[0]);
    COV_COMPARE: cover property (IRQ_COMPARE[1] && !PIN_OE_N[3]);
    COV_WRAP: cover property (tick && r.count == `CC_TIMER_MAX);
    COV_HALF_RATE: cover property (tick && r.ctrl.tick_resolution_select);

endmodule : cc_unit

`default_nettype wire

// *** pkg/cc_params.svh ***
// register map, reset values and timing constants of the capture/compare unit
`ifndef CC_PARAMS_SVH
`define CC_PARAMS_SVH

`define CC_ADDR_W 4
`define CC_REG_CTRL 4'h0
`define CC_REG_SEL 4'h1
`define CC_REG_SNAP_HI 4'h2
`define CC_REG_SNAP_LO 4'h3
`define CC_REG_CAP0_HI 4'h4
`define CC_REG_CAP0_LO 4'h5
`define CC_REG_CAP1_HI 4'h6
`define CC_REG_CAP1_LO 4'h7
`define CC_REG_CMP0_HI 4'h8
`define CC_REG_CMP0_LO 4'h9
`define CC_REG_CMP1_HI 4'hA
`define CC_REG_CMP1_LO 4'hB

`define CC_BYTE_RESET 8'h00
`define CC_TIMER_RESET 16'h0000
`define CC_TIMER_MAX 16'hFFFF
`define CC_TIMER_STEP 16'h0001
`define CC_PINS_RELEASED 4'hF
`define CC_PINS_LOW 4'h0

`define CC_CLK_PERIOD_NS 25
`define CC_TICK_FULL_NS 1000
`define CC_TICK_HALF_NS 500
`define CC_TICK_FULL_CYC (`CC_TICK_FULL_NS / `CC_CLK_PERIOD_NS)
`define CC_TICK_HALF_CYC (`CC_TICK_HALF_NS / `CC_CLK_PERIOD_NS)
`define CC_DIV_W 6

`endif

// *** pkg/cc_pkg.sv ***
// types shared by the capture/compare unit and its sub-blocks
`default_nettype none
`include "cc_params.svh"

package cc_pkg;

    // register port request, one cycle per access
    typedef struct packed {
        logic [`CC_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    // control register layout, bit 0 at the bottom
    typedef struct packed {
        logic [1:0] spare;
        logic [1:0] compare_match_level;
        logic [1:0] capture_edge_select;
        logic snapshot_request_bit;
        logic tick_resolution_select;
    } ctrl_s;

    // pin select register layout
    typedef struct packed {
        logic [3:0] spare;
        logic [1:0] compare_activate_bit;
        logic [1:0] capture_activate_bit;
    } sel_s;

    typedef struct packed {
        logic [`CC_DIV_W-1:0] cnt;
        logic tick;
    } tick_state_s;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [15:0] value;
        logic hit;
    } cap_state_s;

    typedef struct packed {
        ctrl_s ctrl;
        sel_s sel;
        logic [15:0] count;
        logic [15:0] snap;
        logic [1:0][15:0] cmp;
        logic [1:0][7:0] cmp_hi;
        logic [1:0] cmp_lvl;
        logic [1:0] irq_cmp;
        logic [1:0] irq_cap;
        logic [3:0] pin_out;
        logic [3:0] pin_oe_n;
        logic [7:0] rdata;
    } cc_state_s;

endpackage : cc_pkg

`default_nettype wire

// *** verification/cc_pin_partner.sv ***
// external pin driver model for the capture pins of the capture/compare unit
`default_nettype none

module cc_pin_partner (
    input wire logic clk,
    input wire logic [1:0] want,
    input wire logic [3:0] lag,
    output logic [1:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_cnt;

    // pins start low so no edge is seen right after reset
    initial begin
        pins = 2'b00;
        wait_cnt = 4'h0;
    end

    // a slow driver: the requested level shows lag+1 clocks after the request
    always @(posedge clk) begin
        if (pins == want) begin
            wait_cnt <= 4'h0;
        end else if (wait_cnt >= lag) begin
            pins <= want;
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : cc_pin_partner

`default_nettype wire

// *** verification/test_timer_capture_compare_unit.sv ***
// self-checking bench of the capture/compare unit
`default_nettype none
`include "cc_params.svh"

module test_timer_capture_compare_unit;
    timeunit 1ns;
    timeprecision 1ps;
    import cc_pkg::*;

    logic clk, rst, twi_sel;
    bus_req_s bus;
    logic [1:0] cap_pins, want, twi_out, twi_oe_n, lvl_now;
    logic [3:0] lag, gpio_out, gpio_oe_n, pin_out, pin_oe_n, seen, m;
    logic [7:0] rdata, ctrl_v, d, h, ep;
    logic [1:0] irq_cap, irq_cmp;
    logic [15:0] s0, s1, t;
    logic [31:0] rnd;
    int fail_count, compares;

    cc_unit u_cc_unit (.CLK(clk), .RST(rst), .BUS(bus), .CAPTURE_PIN_IN(cap_pins),
        .GPIO_OUT(gpio_out), .GPIO_OE_N(gpio_oe_n), .TWI_SEL(twi_sel), .TWI_OUT(twi_out),
        .TWI_OE_N(twi_oe_n), .RDATA(rdata), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
        .IRQ_CAPTURE(irq_cap), .IRQ_COMPARE(irq_cmp));
    cc_pin_partner u_cc_pin_partner (.clk(clk), .want(want), .lag(lag), .pins(cap_pins));

    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // pin mux expectation: two-wire first, capture/compare next, port last
    function automatic logic [7:0] exp_pins(logic [3:0] sel, logic tw, logic [1:0] to,
        logic [1:0] toe, logic [3:0] go, logic [3:0] goe, logic [1:0] lv);
        logic [3:0] o, e;
        o = go;
        e = goe;
        if (sel[0]) e[0] = 1'b1;
        if (sel[1]) e[1] = 1'b1;
        if (sel[2]) {o[2], e[2]} = {lv[0], 1'b0};
        if (sel[3]) {o[3], e[3]} = {lv[1], 1'b0};
        if (tw) {o[0], e[0], o[2], e[2]} = {to[0], toe[0], to[1], toe[1]};
        return {o, e};
    endfunction : exp_pins

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk) bus <= '0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk) bus <= '0;
        #1 v = rdata;
    endtask : rd

    task automatic get_count(output logic [15:0] c);
        logic [7:0] hi, lo;
        wr(`CC_REG_CTRL, ctrl_v | 8'h02);
        rd(`CC_REG_SNAP_HI, hi);
        rd(`CC_REG_SNAP_LO, lo);
        c = {hi, lo};
    endtask : get_count

    // returns at the first masked interrupt pulse or after n clocks
    task automatic watch(input logic [3:0] mask, input int n, output logic [3:0] s);
        s = 4'h0;
        for (int i = 0; i < n && s == 4'h0; i++) begin
            @(posedge clk);
            #1 s = {irq_cmp, irq_cap} & mask;
        end
    endtask : watch

    task automatic conclude();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard, well beyond the few thousand clocks the sequence needs
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        conclude();
    end

    initial begin
        {rst, bus, want, lag, twi_sel, twi_out, twi_oe_n} = {1'b1, 14'h0, 2'b00, 4'h0, 5'h03};
        {gpio_out, gpio_oe_n, ctrl_v, lvl_now, fail_count, compares} = '0;
        gpio_oe_n = 4'hF; // core port idles as input after reset
        rnd = 32'h353d;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 check("oe_after_reset", 16'h000F, {12'h0, pin_oe_n});
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], d);
            check("reg_after_reset", 16'h0000, {8'h0, d});
        end
        // timer rate at both resolutions: K ticks between two snapshots
        for (int half = 0; half < 2; half++) begin
            ctrl_v = {7'h0, half[0]};
            wr(`CC_REG_CTRL, ctrl_v);
            repeat (50) @(posedge clk);
            get_count(s0);
            repeat (half ? 74 : 114) @(posedge clk);
            get_count(s1);
            check("timer_steps", half ? 16'h0004 : 16'h0003, s1 - s0);
        end
        repeat (100) @(posedge clk);
        wr(`CC_REG_SNAP_HI, ~s1[15:8]);
        rd(`CC_REG_SNAP_HI, d);
        rd(`CC_REG_SNAP_LO, h);
        check("snapshot_held", s1, {d, h});
        ctrl_v = 8'h00;
        wr(`CC_REG_CTRL, ctrl_v | 8'hC2);
        rd(`CC_REG_CTRL, d);
        check("ctrl_spare", 16'h0000, {8'h0, d});
        // capture: every channel with both edge senses, other edge ignored
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr_next(rnd);
            lag <= rnd[3:0] & 4'h7;
            want <= {2{~k[1]}};
            repeat (20) @(posedge clk);
            ctrl_v = {4'h0, {2{k[1]}}, 2'b00};
            wr(`CC_REG_CTRL, ctrl_v);
            wr(`CC_REG_SEL, 8'h01 << k[0]);
            get_count(s0);
            want[k[0]] <= k[1];
            watch(4'h3, 20, seen);
            check("capture_irq", 16'h0001 << k[0], {12'h0, seen});
            @(posedge clk);
            #1 check("irq_one_cycle", 16'h0000, {14'h0, irq_cap});
            get_count(s1);
            rd(k[0] ? `CC_REG_CAP1_HI : `CC_REG_CAP0_HI, d);
            rd(k[0] ? `CC_REG_CAP1_LO : `CC_REG_CAP0_LO, h);
            check("capture_in_span", 16'h0001, {15'h0, {d, h} >= s0 && {d, h} <= s1});
            want[k[0]] <= ~k[1];
            watch(4'h3, 20, seen);
            check("other_edge_quiet", 16'h0000, {12'h0, seen});
        end
        // compare: each channel, high then low level, other channel silent
        for (int k = 0; k < 4; k++) begin
            ctrl_v = {2'b00, 2'(k[0] ? {~k[1], 1'b0} : {1'b0, ~k[1]}), 4'h0};
            wr(`CC_REG_CTRL, ctrl_v);
            wr(`CC_REG_SEL, 8'h04 << k[0]);
            rnd = lfsr_next(rnd);
            get_count(s0);
            t = s0 + 16'h0003 + 16'(rnd[1:0]);
            wr(k[0] ? `CC_REG_CMP1_HI : `CC_REG_CMP0_HI, t[15:8]);
            wr(k[0] ? `CC_REG_CMP1_LO : `CC_REG_CMP0_LO, t[7:0]);
            watch(4'hC, 400, seen);
            check("compare_irq", 16'h0004 << k[0], {12'h0, seen});
            lvl_now[k[0]] = ~k[1];
            @(posedge clk);
            #1 check("compare_pin", {15'h0, ~k[1]}, {15'h0, pin_out[2 + k[0]]});
            check("compare_drive", 16'h0000, {15'h0, pin_oe_n[2 + k[0]]});
            wr(k[0] ? `CC_REG_CMP1_HI : `CC_REG_CMP0_HI, ~t[15:8]);
            rd(k[0] ? `CC_REG_CMP1_HI : `CC_REG_CMP0_HI, d);
            check("hi_waits_for_lo", {8'h0, t[15:8]}, {8'h0, d});
            wr(k[0] ? `CC_REG_CMP1_LO : `CC_REG_CMP0_LO, t[7:0]);
            rd(k[0] ? `CC_REG_CMP1_HI : `CC_REG_CMP0_HI, d);
            check("hi_after_lo", {8'h0, ~t[15:8]}, {8'h0, d});
        end
        // random pin ownership mixes against the priority order
        for (int k = 0; k < 24; k++) begin
            rnd = lfsr_next(rnd);
            {twi_sel, twi_out, twi_oe_n, gpio_out, gpio_oe_n} <= rnd[12:0];
            wr(`CC_REG_SEL, rnd[20:13]);
            @(posedge clk);
            #1 m = {2'b00, rnd[14:13] & {~rnd[12], 1'b1}};
            ep = exp_pins(rnd[16:13], rnd[12], rnd[11:10], rnd[9:8], rnd[7:4], rnd[3:0],
                lvl_now);
            check("pin_oe", {12'h0, ep[3:0]}, {12'h0, pin_oe_n});
            check("pin_out", {12'h0, ep[7:4] | m}, {12'h0, pin_out | m});
            rd(`CC_REG_SEL, d);
            check("sel_spare", {8'h0, rnd[20:13] & 8'h0F}, {8'h0, d});
        end
        conclude();
    end
endmodule : test_timer_capture_compare_unit

`default_nettype wire
